//--- src/pmu_sleep_sequencer_irq.sv
// Power sequencing, sleep entry and exit, supervision and interrupt pin
//
// How it works
// - Sleep: Buck3 to level, 2ms, Buck2, 2ms, Buck1
// - Sleep pin high disables Bucks1/2, Buck3 sleeps
// - Sleep pin ignored for one second after power-up
// - Bucks1/2 already off: Buck3 keeps its setting
// - Wake: Buck1, 2ms, then Buck2 and Buck3
// - Sleep stops clocks, Buck3 pulse-frequency only
// - Select pins choose Buck2 and Buck3 startup levels
// - Select pins sampled only during startup
// - Undervoltage: all bucks off, reset, rerun power-up
// - Overvoltage: everything off, reset, rerun power-up
// - Overtemperature: reset, all off, restart fresh
// - Status register live, never cleared by read
// - Five conditions: four outputs and comparator
// - Enable register gates status and interrupt
// - Status read leaves interrupt pin unchanged
// - Threshold code defaults to 0x19
// - Polarity bit selects interrupt pin sense
// - Control bit doubles comparator hysteresis
// - Reset pin restores every register default
`timescale 1ns/100ps
`include "pmu_params.svh"
module pmu_sleep_sequencer_irq #(
    parameter int BOOT_CYCLES       = `BOOT_CYCLES,
    parameter int STEP_CYCLES       = `STEP_CYCLES,
    parameter int SLEEP_GATE_CYCLES = `SLEEP_GATE_CYCLES
) (
    input  wire logic                 CLK,                    // 100 MHz clock
    input  wire logic                 ARST_N,                 // Reset pin, active low
    input  wire logic                 SPI_SCLK,               // Serial clock
    input  wire logic                 SPI_CS_N,               // Serial select, active low
    input  wire logic                 SPI_MOSI,               // Serial data in
    output logic                      SPI_MISO,               // Serial data out
    input  wire logic                 SLEEP_REQUEST_PIN,      // Sleep request
    input  wire logic                 BUCK2_VOLTAGE_SELECT,   // Buck2 level strap
    input  wire logic                 BUCK3_VOLTAGE_SELECT,   // Buck3 level strap
    input  wire logic                 UNDERVOLTAGE_LOCKOUT,   // Supply too low
    input  wire logic                 OVERVOLTAGE_LOCKOUT,    // Supply too high
    input  wire logic                 THERMAL_SHUTDOWN,       // Die too hot
    input  wire logic [3:0]           PGOOD,                  // Over flag level: B1,B2,B3,LDO
    input  wire logic                 COMPARATOR_INPUT_ABOVE, // Comparator above threshold
    output logic                      BUCK1_EN,               // Buck1 enable
    output logic                      BUCK2_EN,               // Buck2 enable
    output logic                      BUCK3_EN,               // Buck3 enable
    output logic                      LDO_EN,                 // Regulator enable
    output logic [7:0]                BUCK3_CODE,             // Buck3 level code
    output logic                      BUCK2_HIGH,             // Buck2 at upper level
    output logic                      PULSE_FREQUENCY_MODE,   // Buck3 restricted mode
    output logic                      CLOCKS_STOP,            // Internal clocks off
    output logic [`THRESH_W-1:0]      COMP_THRESHOLD,         // Threshold code
    output logic                      COMP_HYST_DOUBLE,       // Double hysteresis
    output logic                      IRQ_PIN                 // Interrupt pin level
);
    typedef struct packed {
        pmu_pkg::seq_state_e state;
        pmu_pkg::regs_s      regs;
        pmu_pkg::pins_s      sync1;
        pmu_pkg::pins_s      sync2;
        logic [1:0]          up_step;
        logic                ldo_on;
        logic                b1_live;
        logic                b2_live;
        logic                b3_live;
        logic                b3_sleep;
        logic                b2_high;
        logic [`IRQ_W-1:0]   status;
        logic                o_b1;
        logic                o_b2;
        logic                o_b3;
        logic                o_ldo;
        logic [7:0]          o_code;
        logic                o_lp;
        logic                o_irq;
    } top_s;

    top_s s;
    top_s next_s;
    pmu_pkg::pins_s p;
    logic                ld_step;
    logic                ld_gate;
    logic [`TMR_W-1:0]   step_len;
    logic                step_done;
    logic                gate_done;
    logic [`ADDR_W-1:0]  addr;
    logic [7:0]          wdata;
    logic                wr;
    logic [7:0]          rdata;
    logic                fault;
    logic                req;

    function automatic pmu_pkg::regs_s reg_defaults();
        pmu_pkg::regs_s r;
        r.buck3_voltage            = `B3_CODE_1V2;
        r.sleep_level              = `RST_SLEEP_LEVEL;
        r.converter_enable         = `RST_CONV_ENABLE;
        r.comparator_control       = `RST_COMP_CONTROL;
        r.irq_enable               = `RST_IRQ_ENABLE;
        r.regulator_sleep_polarity = `RST_SLEEP_POL;
        return r;
    endfunction

    // Status is reloaded every cycle from the masked inputs, so reads have no side effect
    function automatic logic [7:0] read_reg(input logic [`ADDR_W-1:0] a, input pmu_pkg::regs_s r,
                                            input logic [`IRQ_W-1:0] st);
        case (a)
            `REG_BUCK3_VOLTAGE: read_reg = r.buck3_voltage;
            `REG_SLEEP_LEVEL:   read_reg = r.sleep_level;
            `REG_CONV_ENABLE:   read_reg = r.converter_enable;
            `REG_COMP_CONTROL:  read_reg = r.comparator_control;
            `REG_IRQ_ENABLE:    read_reg = r.irq_enable;
            `REG_IRQ_STATUS:    read_reg = 8'(st);
            `REG_SLEEP_POL:     read_reg = r.regulator_sleep_polarity;
            default:            read_reg = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    spi_regport u_spi (
        .clk    (CLK),
        .arst_n (ARST_N),
        .sclk   (SPI_SCLK),
        .cs_n   (SPI_CS_N),
        .mosi   (SPI_MOSI),
        .rdata  (rdata),
        .miso   (SPI_MISO),
        .addr   (addr),
        .wdata  (wdata),
        .wr     (wr)
    );

    step_timer u_step (
        .clk    (CLK),
        .arst_n (ARST_N),
        .load   (ld_step),
        .cycles (step_len),
        .done   (step_done)
    );

    step_timer u_gate (
        .clk    (CLK),
        .arst_n (ARST_N),
        .load   (ld_gate),
        .cycles (`TMR_W'(SLEEP_GATE_CYCLES)),
        .done   (gate_done)
    );

    assign rdata = read_reg(addr, s.regs, s.status);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        ld_step = 1'b0;
        ld_gate = 1'b0;
        step_len = `TMR_W'(STEP_CYCLES);
        p = s.sync2;
        next_s.sync1 = '{SLEEP_REQUEST_PIN, BUCK2_VOLTAGE_SELECT, BUCK3_VOLTAGE_SELECT,
                         UNDERVOLTAGE_LOCKOUT, OVERVOLTAGE_LOCKOUT, THERMAL_SHUTDOWN,
                         PGOOD, COMPARATOR_INPUT_ABOVE};
        next_s.sync2 = s.sync1;
        fault = p.undervoltage_lockout | p.overvoltage_lockout | p.thermal_shutdown;
        req = p.sleep_req & gate_done;
        next_s.status = {p.cmp_above, p.pgood} & s.regs.irq_enable[`IRQ_W-1:0];
        if (wr && s.state != pmu_pkg::S_FAULT) begin
            case (addr)
                `REG_BUCK3_VOLTAGE: next_s.regs.buck3_voltage = wdata;
                `REG_SLEEP_LEVEL:   next_s.regs.sleep_level = wdata;
                `REG_CONV_ENABLE:   next_s.regs.converter_enable = wdata;
                `REG_COMP_CONTROL:  next_s.regs.comparator_control = wdata;
                `REG_IRQ_ENABLE:    next_s.regs.irq_enable = wdata;
                `REG_SLEEP_POL:     next_s.regs.regulator_sleep_polarity = wdata;
                default:            next_s.regs = s.regs;
            endcase
        end
        case (s.state)
            pmu_pkg::S_FAULT: begin
                step_len = `TMR_W'(BOOT_CYCLES);
                ld_step = 1'b1;
                ld_gate = 1'b1;
                next_s.state = pmu_pkg::S_BOOT;
            end
            pmu_pkg::S_BOOT: begin
                if (step_done) begin
                    next_s.ldo_on = 1'b1;
                    next_s.b2_high = p.sel_b2;
                    next_s.regs.buck3_voltage = p.sel_b3 ? `B3_CODE_1V2 : `B3_CODE_1V0;
                    next_s.up_step = 2'd0;
                    ld_step = 1'b1;
                    next_s.state = pmu_pkg::S_POWERUP;
                end
            end
            pmu_pkg::S_POWERUP: begin
                if (step_done) begin
                    next_s.up_step = s.up_step + 2'd1;
                    case (s.up_step)
                        2'd0:    next_s.b1_live = 1'b1;
                        2'd1:    next_s.b2_live = 1'b1;
                        default: next_s.b3_live = 1'b1;
                    endcase
                    if (s.up_step == 2'd2) begin
                        next_s.state = pmu_pkg::S_ACTIVE;
                    end else begin
                        ld_step = 1'b1;
                    end
                end
            end
            pmu_pkg::S_ACTIVE: begin
                if (req) begin
                    if (!s.regs.converter_enable[`EN_BUCK1_BIT] && !s.regs.converter_enable[`EN_BUCK2_BIT]) begin
                        next_s.b1_live = 1'b0;
                        next_s.b2_live = 1'b0;
                        next_s.state = pmu_pkg::S_SLEEP;
                    end else begin
                        next_s.b3_sleep = 1'b1;
                        ld_step = 1'b1;
                        next_s.state = pmu_pkg::S_SLP_B3;
                    end
                end
            end
            pmu_pkg::S_SLP_B3: begin
                if (step_done) begin
                    next_s.b2_live = 1'b0;
                    ld_step = 1'b1;
                    next_s.state = pmu_pkg::S_SLP_B2;
                end
            end
            pmu_pkg::S_SLP_B2: begin
                if (step_done) begin
                    next_s.b1_live = 1'b0;
                    next_s.state = pmu_pkg::S_SLEEP;
                end
            end
            pmu_pkg::S_SLEEP: begin
                if (!p.sleep_req) begin
                    next_s.b1_live = 1'b1;
                    ld_step = 1'b1;
                    next_s.state = pmu_pkg::S_WAKE;
                end
            end
            pmu_pkg::S_WAKE: begin
                if (step_done) begin
                    next_s.b2_live = 1'b1;
                    next_s.b3_sleep = 1'b0;
                    next_s.state = pmu_pkg::S_ACTIVE;
                end
            end
            default: begin
                next_s.state = pmu_pkg::S_FAULT;
            end
        endcase
        if (fault) begin
            next_s.state = pmu_pkg::S_FAULT;
            next_s.regs = reg_defaults();
            next_s.up_step = 2'd0;
            next_s.b1_live = 1'b0;
            next_s.b2_live = 1'b0;
            next_s.b3_live = 1'b0;
            next_s.b3_sleep = 1'b0;
            // Undervoltage alone leaves the regulator running
            next_s.ldo_on = s.ldo_on & ~(p.overvoltage_lockout | p.thermal_shutdown);
        end
        next_s.o_b1 = next_s.b1_live & next_s.regs.converter_enable[`EN_BUCK1_BIT];
        next_s.o_b2 = next_s.b2_live & next_s.regs.converter_enable[`EN_BUCK2_BIT];
        next_s.o_b3 = next_s.b3_live;
        next_s.o_ldo = next_s.ldo_on;
        next_s.o_code = next_s.b3_sleep ? next_s.regs.sleep_level : next_s.regs.buck3_voltage;
        next_s.o_lp = (next_s.state == pmu_pkg::S_SLEEP) |
                      next_s.regs.regulator_sleep_polarity[`REG_SLEEP_BIT];
        next_s.o_irq = s.regs.regulator_sleep_polarity[`POL_BIT] ? (|s.status) : ~(|s.status);
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s <= '{state: pmu_pkg::S_FAULT, regs: reg_defaults(), o_irq: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign BUCK1_EN = s.o_b1;
    assign BUCK2_EN = s.o_b2;
    assign BUCK3_EN = s.o_b3;
    assign LDO_EN = s.o_ldo;
    assign BUCK3_CODE = s.o_code;
    assign BUCK2_HIGH = s.b2_high;
    assign PULSE_FREQUENCY_MODE = s.o_lp;
    assign CLOCKS_STOP = s.o_lp;
    assign IRQ_PIN = s.o_irq;
    assign COMP_THRESHOLD = s.regs.comparator_control[`THRESH_W-1:0];
    assign COMP_HYST_DOUBLE = s.regs.comparator_control[`HYST_X2_BIT];

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    AST_B1_AFTER_B2: assert property (
        $fell(s.b1_live) && $past(s.state) == pmu_pkg::S_SLP_B2 && !$past(fault) |-> !s.b2_live && $past(step_done))
        else $error("Buck1 dropped before Buck2 step completed");
    AST_SLEEP_LEVEL: assert property (
        s.state == pmu_pkg::S_SLP_B3 && !fault |=> BUCK3_CODE == s.regs.sleep_level)
        else $error("Buck3 not at sleep level during sleep entry");
    AST_GATE: assert property (
        s.state == pmu_pkg::S_ACTIVE && !gate_done && !fault |=> s.state == pmu_pkg::S_ACTIVE)
        else $error("Sleep entered before gate expired");
    AST_NO_MOVE: assert property (
        s.state == pmu_pkg::S_ACTIVE && !fault && req && !BUCK1_EN && !BUCK2_EN && s.b1_live
        |=> s.state == pmu_pkg::S_SLEEP && !s.b3_sleep)
        else $error("Buck3 moved although Bucks 1 and 2 were off");
    AST_WAKE_ORDER: assert property (
        $rose(s.state == pmu_pkg::S_WAKE) |-> s.b1_live && !s.b2_live && $stable(s.b3_sleep) ##1 !s.b2_live)
        else $error("Wake order broken");
    AST_LOW_POWER: assert property (
        s.state == pmu_pkg::S_SLEEP |-> PULSE_FREQUENCY_MODE && CLOCKS_STOP)
        else $error("Sleep without restricted mode");
    AST_STRAP_HOLD: assert property (
        s.state == pmu_pkg::S_ACTIVE |=> $stable(BUCK2_HIGH))
        else $error("Strap level changed after startup");
    AST_FAULT_OFF: assert property (
        fault |=> !BUCK3_EN && !BUCK1_EN && !BUCK2_EN && s.state == pmu_pkg::S_FAULT)
        else $error("Lockout did not shut bucks");
    AST_STATUS_LIVE: assert property (
        ##1 s.status == ($past({p.cmp_above, p.pgood}) & $past(s.regs.irq_enable[`IRQ_W-1:0])))
        else $error("Status not live and masked");
    AST_IRQ_POL: assert property (
        ##1 IRQ_PIN == ($past(s.regs.regulator_sleep_polarity[`POL_BIT]) ~^ $past(|s.status)))
        else $error("Interrupt pin sense wrong");

    COV_SLEEP: cover property (s.state == pmu_pkg::S_SLP_B2 ##1 s.state == pmu_pkg::S_SLEEP);
    COV_WAKE: cover property (s.state == pmu_pkg::S_WAKE ##1 s.state == pmu_pkg::S_ACTIVE);
    COV_FAULT: cover property (s.state == pmu_pkg::S_ACTIVE ##1 s.state == pmu_pkg::S_FAULT);
    COV_IRQ: cover property ($fell(IRQ_PIN));
endmodule // pmu_sleep_sequencer_irq

//--- src/pmu_params.svh
// Constants of the sleep sequencer: timing, register map, fields, defaults
`ifndef PMU_PARAMS_SVH
`define PMU_PARAMS_SVH

`define CLK_PERIOD_NS     10
`define STEP_DELAY_NS     2000000
`define BOOT_DELAY_NS     15000000
`define SLEEP_GATE_NS     1000000000
`define STEP_CYCLES       ((`STEP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOOT_CYCLES       ((`BOOT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_GATE_CYCLES ((`SLEEP_GATE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TMR_W             27

`define ADDR_W            7
`define REG_BUCK3_VOLTAGE 7'h00
`define REG_SLEEP_LEVEL   7'h09
`define REG_CONV_ENABLE   7'h0A
`define REG_COMP_CONTROL  7'h0B
`define REG_IRQ_ENABLE    7'h0C
`define REG_IRQ_STATUS    7'h0D
`define REG_SLEEP_POL     7'h0E

`define EN_BUCK1_BIT      0
`define EN_BUCK2_BIT      1
`define HYST_X2_BIT       7
`define THRESH_W          7
`define POL_BIT           0
`define REG_SLEEP_BIT     1
`define IRQ_W             5

`define RST_SLEEP_LEVEL   8'h1E
`define RST_CONV_ENABLE   8'h03
`define RST_COMP_CONTROL  8'h19
`define RST_IRQ_ENABLE    8'h10
`define RST_SLEEP_POL     8'h00
`define B3_CODE_1V2       8'h32
`define B3_CODE_1V0       8'h1E

`define SPI_FRAME_BITS    16
`endif

//--- src/pmu_pkg.sv
// Types shared by the sequencer, its timer and its serial port
`include "pmu_params.svh"
package pmu_pkg;
    typedef enum logic [7:0] {
        S_FAULT   = 8'h01,
        S_BOOT    = 8'h02,
        S_POWERUP = 8'h04,
        S_ACTIVE  = 8'h08,
        S_SLP_B3  = 8'h10,
        S_SLP_B2  = 8'h20,
        S_SLEEP   = 8'h40,
        S_WAKE    = 8'h80
    } seq_state_e;

    typedef struct packed {
        logic [7:0] buck3_voltage;
        logic [7:0] sleep_level;
        logic [7:0] converter_enable;
        logic [7:0] comparator_control;
        logic [7:0] irq_enable;
        logic [7:0] regulator_sleep_polarity;
    } regs_s;

    typedef struct packed {
        logic       sleep_req;
        logic       sel_b2;
        logic       sel_b3;
        logic       undervoltage_lockout;
        logic       overvoltage_lockout;
        logic       thermal_shutdown;
        logic [3:0] pgood;
        logic       cmp_above;
    } pins_s;

    typedef struct packed {
        logic [`TMR_W-1:0] count;
        logic              done;
    } timer_s;

    typedef struct packed {
        logic [2:0]          sync1;
        logic [2:0]          sync2;
        logic                sclk_q;
        logic [4:0]          bitcnt;
        logic [15:0]         shift;
        logic [`ADDR_W-1:0]  addr;
        logic [7:0]          wdata;
        logic                wr;
        logic                miso;
    } spi_s;
endpackage

//--- src/step_timer.sv
// Down-counter that reports expiry of a loaded cycle count
`timescale 1ns/100ps
`include "pmu_params.svh"
module step_timer (
    input  wire logic              clk,    // System clock
    input  wire logic              arst_n, // Async reset
    input  wire logic              load,   // Start a new count
    input  wire logic [`TMR_W-1:0] cycles, // Count to load
    output logic                   done    // Count has expired
);
    pmu_pkg::timer_s s;
    pmu_pkg::timer_s n;

    always_comb begin
        n = s;
        if (load) begin
            n.count = cycles;
        end else if (s.count != '0) begin
            n.count = s.count - `TMR_W'(1);
        end
        n.done = (n.count == '0);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign done = s.done;
endmodule // step_timer

//--- src/spi_regport.sv
// Serial register port: 16-bit frames, rw bit, 7-bit address, 8-bit data
`timescale 1ns/100ps
`include "pmu_params.svh"
module spi_regport (
    input  wire logic               clk,    // System clock
    input  wire logic               arst_n, // Async reset
    input  wire logic               sclk,   // Serial clock pin
    input  wire logic               cs_n,   // Chip select pin
    input  wire logic               mosi,   // Serial data in pin
    input  wire logic [7:0]         rdata,  // Read value for addr
    output logic                    miso,   // Serial data out
    output logic [`ADDR_W-1:0]      addr,   // Frame address
    output logic [7:0]              wdata,  // Write data
    output logic                    wr      // Write strobe pulse
);
    pmu_pkg::spi_s s;
    pmu_pkg::spi_s n;
    logic rise;
    logic fall;
    logic [15:0] word;

    always_comb begin
        n = s;
        n.sync1 = {mosi, cs_n, sclk};
        n.sync2 = s.sync1;
        n.sclk_q = s.sync2[0];
        n.wr = 1'b0;
        rise = s.sync2[0] & ~s.sclk_q;
        fall = ~s.sync2[0] & s.sclk_q;
        word = {s.shift[14:0], s.sync2[2]};
        if (s.sync2[1]) begin
            n.bitcnt = '0;
        end else if (rise) begin
            n.shift = word;
            n.bitcnt = s.bitcnt + 5'h01;
            if (s.bitcnt == 5'h07) begin
                n.addr = word[`ADDR_W-1:0];
            end
            // Frame of 16 bits with rw low commits a write
            if (s.bitcnt == 5'(`SPI_FRAME_BITS - 1) && !word[15]) begin
                n.wr = 1'b1;
                n.wdata = word[7:0];
            end
        end else if (fall && s.bitcnt[3] && !s.bitcnt[4]) begin
            n.miso = rdata[~s.bitcnt[2:0]];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign miso = s.miso;
    assign addr = s.addr;
    assign wdata = s.wdata;
    assign wr = s.wr;
endmodule // spi_regport

//--- tb/spi_host.sv
// Host model: serial master framing register reads and writes
`timescale 1ns/100ps
module spi_host (
    output logic      sclk, // Serial clock, idle low
    output logic      cs_n, // Select, active low
    output logic      mosi, // Host data out
    input  wire logic miso  // Device data out
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Mode 0, MSB first; 60 ns halves keep well above the sync floor
    task xfer(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {rd, a, d};
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = f[i];
            #60 sclk = 1'b1;
            if (i < 8) q[i] = miso;
            #60 sclk = 1'b0;
        end
        #60 cs_n = 1'b1;
        // Idle data line does not hold its last bit
        mosi = ~mosi;
        #100;
    endtask
endmodule // spi_host

//--- tb/pmu_sleep_sequencer_irq_tb.sv
// Bench for the sleep sequencer: registers, sleep pin, interrupt pin, lockouts
`timescale 1ns/100ps
module pmu_sleep_sequencer_irq_tb;
    logic clk = 1'b0, arst_n = 1'b0, slp = 1'b0, sel2 = 1'b1, sel3 = 1'b0, uv = 1'b0, ov = 1'b0, thermal_shutdown = 1'b0;
    logic cmp = 1'b0, sclk, cs_n, mosi, miso, b1, b2, b3, ldo, b2h, pulse_frequency_mode, cstop, hyst, irq;
    logic [3:0] pg = 4'h0;
    logic [7:0] code, q;
    logic [6:0] thr;
    int bad_count = 0, checks_done = 0;
    always #5 clk = ~clk;
    spi_host HOST (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    // Short counts keep the run small
    // Gate outlasts power-up so an early request is seen being ignored
    pmu_sleep_sequencer_irq #(.BOOT_CYCLES(20), .STEP_CYCLES(10), .SLEEP_GATE_CYCLES(2000)) DUT (
        .CLK(clk), .ARST_N(arst_n), .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .SPI_MISO(miso),
        .SLEEP_REQUEST_PIN(slp), .BUCK2_VOLTAGE_SELECT(sel2), .BUCK3_VOLTAGE_SELECT(sel3),
        .UNDERVOLTAGE_LOCKOUT(uv), .OVERVOLTAGE_LOCKOUT(ov), .THERMAL_SHUTDOWN(thermal_shutdown), .PGOOD(pg),
        .COMPARATOR_INPUT_ABOVE(cmp), .BUCK1_EN(b1), .BUCK2_EN(b2), .BUCK3_EN(b3), .LDO_EN(ldo),
        .BUCK3_CODE(code), .BUCK2_HIGH(b2h), .PULSE_FREQUENCY_MODE(pulse_frequency_mode), .CLOCKS_STOP(cstop),
        .COMP_THRESHOLD(thr), .COMP_HYST_DOUBLE(hyst), .IRQ_PIN(irq));
    ////////////////////////////////////////////////////////////////
    task wrap_up;
        if (bad_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task wr(input logic [6:0] a, input logic [7:0] d);
        HOST.xfer(1'b0, a, d, q);
    endtask
    task rd(input logic [6:0] a, input logic [7:0] e);
        HOST.xfer(1'b1, a, 8'h00, q);
        chk(q, e);
    endtask
    task wait_up;
        int n;
        n = 0;
        while (b3 !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        if (n >= 300) begin
            bad_count++;
            wrap_up;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        cyc(6);
        arst_n = 1'b1;
        // Request held from reset must stay ignored until the gate expires
        slp = 1'b1;
        wait_up;
        cyc(5);
        chk({b1, b2, code}, 10'h31E);
        slp = 1'b0;
        rd(7'h09, 8'h1E);
        rd(7'h0A, 8'h03);
        rd(7'h0B, 8'h19);
        rd(7'h0C, 8'h10);
        rd(7'h0E, 8'h00);
        rd(7'h05, 8'h00);
        wait_up;
        chk(b2h, 1'b1);
        chk(code, 8'h1E);
        sel2 = 1'b0;
        sel3 = 1'b1;
        cyc(10);
        chk({b2h, code}, 9'h11E);
        chk(thr, 7'h19);
        wr(7'h0B, 8'h99);
        chk({hyst, thr}, 8'h99);
        pg = 4'hF;
        cmp = 1'b1;
        wr(7'h0C, 8'h1F);
        rd(7'h0D, 8'h1F);
        chk(irq, 1'b0);
        rd(7'h0D, 8'h1F);
        chk(irq, 1'b0);
        pg = 4'h5;
        cyc(5);
        rd(7'h0D, 8'h15);
        wr(7'h0C, 8'h10);
        wr(7'h0E, 8'h01);
        chk(irq, 1'b1);
        cmp = 1'b0;
        cyc(5);
        chk(irq, 1'b0);
        wr(7'h0E, 8'h00);
        chk(irq, 1'b1);
        wr(7'h0C, 8'h00);
        cmp = 1'b1;
        cyc(5);
        chk(irq, 1'b1);
        rd(7'h0D, 8'h00);
        wr(7'h0E, 8'h02);
        chk(pulse_frequency_mode, 1'b1);
        wr(7'h0E, 8'h00);
        chk(pulse_frequency_mode, 1'b0);
        wr(7'h00, 8'h40);
        wr(7'h09, 8'h22);
        slp = 1'b1;
        cyc(6);
        chk({b1, b2, code}, 10'h322);
        cyc(10);
        chk({b1, b2}, 2'b10);
        cyc(10);
        chk({b1, b2, cstop}, 3'b001);
        slp = 1'b0;
        cyc(6);
        chk({b1, b2, code}, 10'h222);
        cyc(10);
        chk({b1, b2, code}, 10'h340);
        wr(7'h0A, 8'h00);
        slp = 1'b1;
        cyc(30);
        chk({b1, b2, code}, 10'h040);
        slp = 1'b0;
        for (int k = 0; k < 3; k++) begin
            wr(7'h09, 8'h22);
            {uv, ov, thermal_shutdown} = 3'b100 >> k;
            cyc(5);
            chk({b1, b2, b3, ldo}, {3'b000, k == 0});
            {uv, ov, thermal_shutdown} = 3'b000;
            wait_up;
            rd(7'h09, 8'h1E);
        end
        // Mid-run reset pin pulse
        wr(7'h09, 8'h22);
        arst_n = 1'b0;
        cyc(2);
        chk({b1, b2, b3, ldo, irq}, 5'h01);
        arst_n = 1'b1;
        rd(7'h09, 8'h1E);
        wrap_up;
    end
endmodule // pmu_sleep_sequencer_irq_tb
